// file: core/tsense_consts.svh
`ifndef TSENSE_CONSTS_SVH
`define TSENSE_CONSTS_SVH

// Pointer values that select the readable and writable registers.
`define PTR_TEMP 2'h0
`define PTR_CFG 2'h1
`define PTR_HIGH 2'h2
`define PTR_LOW 2'h3

// Power-on contents of the pointer and the data registers.
`define RST_PTR 2'h0
`define RST_CFG 8'h40
`define RST_HIGH 8'h7f
`define RST_LOW 8'h80

// Configuration field positions.
`define CFG_PD 7
`define CFG_FILT 6
`define CFG_ALERT_DIS 5
`define CFG_POL 4
`define CFG_ALERT_CLR 3
`define CFG_ONE_SHOT 2

// Fixed upper address nibble and the bus-wide alert response address.
`define ADDR_HI 4'h9
`define ARA_ADDR 7'h0c

// Bits in a byte and toggle event numbering from the link to the core.
`define BYTE_BITS 4'h8
`define EV_WORD 0
`define EV_CLR 1
`define EV_RDCLR 2
`define EV_SHOT 3

`endif

// file: core/tsense_pkg.sv
package tsense_pkg;

  // Level seen on the address-select pin by the pad sense circuit.
  typedef enum logic [1:0] {
    AS_GND = 2'h0,
    AS_VDD = 2'h1,
    AS_FLOAT = 2'h2
  } strap_t;

  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_WR = 7'h08,
    S_WACK = 7'h10,
    S_RD = 7'h20,
    S_RACK = 7'h40
  } link_state_t;

  // State of the logic on the link clock.
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [1:0] pub_s;
    logic pub_seen;
    logic [12:0] snap;
    logic [3:0] as_s;
    logic [1:0] as_wait;
    logic as_done;
    logic [6:0] addr7;
    link_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [1:0] nbyte;
    logic rw;
    logic ara;
    logic mack;
    logic [1:0] ptr;
    logic [7:0] cfg;
    logic [7:0] thigh;
    logic [7:0] tlow;
    logic [3:0] tog;
    logic sda_oe;
    logic sda_out;
  } link_st_t;

  // State of the logic on the system clock.
  typedef struct packed {
    logic [3:0] tog_s1;
    logic [3:0] tog_s2;
    logic [3:0] tog_seen;
    logic [7:0] cfg;
    logic [7:0] thigh;
    logic [7:0] tlow;
    logic [9:0] temp;
    logic alert;
    logic over_hi;
    logic under_lo;
    logic [12:0] pub;
    logic pub_tog;
    logic [1:0] ack_s;
    logic alert_oe;
    logic alert_out;
    logic pd;
    logic filt;
    logic shot;
  } core_st_t;

endpackage : tsense_pkg

// file: core/temp_sensor_i2c_slave_alert.sv
`timescale 1ns/10ps
`include "tsense_consts.svh"
// Behaviour
// - Eight-bit low limit; temperature below it deasserts an enabled alert.
// - Bus address is 1001 followed by three version-set bits.
// - Address-select pin ground, supply or floating picks one of three low variants.
// - Start is SDA falling with SCL high; eight bits follow, MSB first.
// - Matching address is acknowledged by pulling SDA low; otherwise idle until start.
// - Direction bit 0 means master write, 1 means master read.
// - Nine clocks per byte; SDA changes only while SCL is low.
// - Direction is fixed per transfer; changing it needs a new start.
// - Address plus pointer byte only updates the pointer.
// - Address, pointer, one data byte writes configuration or a limit.
// - Reads return the pointed register; the pointer persists.
// - Temperature reads as two bytes; other registers as one byte.
// - Alert is open-drain; configuration D4 picks polarity, default active low.
// - Configuration D5 set disables the alert, cleared enables it.
// - Alert response address acknowledged only while alerting; arbitration decides.
// - Alert sets above high limit; clears on D3 write or below low limit.
// - Reset: pointer to temperature, high 7F, low 80, configuration 40.
// - Pointer 0 temperature, 1 configuration, 2 high limit, 3 low limit.
// - Ten-bit result; second byte holds two LSBs, alert, high, low flags, zeros.
// - High and low flags clear on second-byte read, set again if still true.
// - D7 power-down, D6 filter; D3 and D2 act on 1 and read 0.

module temp_sensor_i2c_slave_alert #(
  parameter bit HAS_LIMITS = 1'b1,
  parameter logic [2:0] LOW_GND = 3'h0,
  parameter logic [2:0] LOW_VDD = 3'h1,
  parameter logic [2:0] LOW_FLOAT = 3'h2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire tsense_pkg::strap_t address_select_pin,
  input wire logic [9:0] temp_in,
  input wire logic temp_load,
  output logic alert_out,
  output logic alert_oe,
  output logic full_power_down,
  output logic bus_filter_on,
  output logic one_shot_start
);
  import tsense_pkg::*;

  // ==========================================================================
  // Link-clock domain: serial engine, pointer and register copies
  link_st_t lq;
  link_st_t ld;
  core_st_t cq;
  core_st_t cd;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rbyte;
  logic tbyte2;

  // Edges are taken only from the second synchroniser stage onward.
  assign scl_rise = lq.scl_s[1] & ~lq.scl_p;
  assign scl_fall = ~lq.scl_s[1] & lq.scl_p;
  assign bus_start = lq.scl_s[1] & lq.scl_p & lq.sda_p & ~lq.sda_s[1];
  assign bus_stop = lq.scl_s[1] & lq.scl_p & ~lq.sda_p & lq.sda_s[1];
  assign tbyte2 = ~lq.ara & (lq.ptr == `PTR_TEMP) & lq.nbyte[0];

  // Byte to send next; the result repeats its byte pair if read further.
  always_comb begin
    if (lq.ara) begin
      rbyte = {lq.addr7, 1'b0};
    end else if (lq.ptr == `PTR_TEMP) begin
      rbyte = lq.nbyte[0] ? {lq.snap[4:3], lq.snap[2:0], 3'h0} : lq.snap[12:5];
    end else if (lq.ptr == `PTR_CFG) begin
      rbyte = lq.cfg;
    end else if (lq.ptr == `PTR_HIGH) begin
      rbyte = lq.thigh;
    end else begin
      rbyte = lq.tlow;
    end
  end

  // Next state of the link domain.
  always_comb begin
    ld = lq;
    ld.scl_s = {lq.scl_s[0], scl_in};
    ld.sda_s = {lq.sda_s[0], sda_in};
    ld.scl_p = lq.scl_s[1];
    ld.sda_p = lq.sda_s[1];
    // Result snapshot arrives by a two-phase handshake from the core.
    ld.pub_s = {lq.pub_s[0], cq.pub_tog};
    if (lq.pub_s[1] != lq.pub_seen) begin
      ld.pub_seen = lq.pub_s[1];
      ld.snap = cq.pub;
    end
    // The strap is caught once, after both synchroniser stages hold the pin's level.
    ld.as_s = {lq.as_s[1:0], address_select_pin};
    ld.as_wait = {lq.as_wait[0], 1'b1};
    if (lq.as_wait[1] && !lq.as_done) begin
      ld.as_done = 1'b1;
      if (lq.as_s[3:2] == AS_GND) begin
        ld.addr7 = {`ADDR_HI, LOW_GND};
      end else if (lq.as_s[3:2] == AS_VDD) begin
        ld.addr7 = {`ADDR_HI, LOW_VDD};
      end else begin
        ld.addr7 = {`ADDR_HI, LOW_FLOAT};
      end
    end
    case (lq.st)
      S_ADDR: begin
        if (scl_rise) begin
          ld.sh = {lq.sh[6:0], lq.sda_s[1]};
          ld.cnt = lq.cnt + 4'h1;
        end else if (scl_fall && lq.cnt == `BYTE_BITS) begin
          ld.cnt = 4'h0;
          ld.nbyte = 2'h0;
          ld.rw = lq.sh[0];
          ld.ara = (lq.sh[7:1] == `ARA_ADDR) & lq.sh[0] & lq.snap[2];
          if (lq.as_done && (lq.sh[7:1] == lq.addr7 || ld.ara)) begin
            ld.st = S_AACK;
            ld.sda_oe = 1'b1;
          end else begin
            ld.st = S_IDLE;
          end
        end
      end
      S_AACK: begin
        if (scl_fall) begin
          if (lq.rw) begin
            ld.st = S_RD;
            ld.sh = rbyte;
            ld.sda_oe = ~rbyte[7];
            ld.nbyte = lq.nbyte + 2'h1;
            ld.tog[`EV_RDCLR] = lq.tog[`EV_RDCLR] ^ tbyte2;
          end else begin
            ld.st = S_WR;
            ld.sda_oe = 1'b0;
          end
        end
      end
      S_WR: begin
        if (scl_rise) begin
          ld.sh = {lq.sh[6:0], lq.sda_s[1]};
          ld.cnt = lq.cnt + 4'h1;
        end else if (scl_fall && lq.cnt == `BYTE_BITS) begin
          ld.st = S_WACK;
          ld.sda_oe = 1'b1;
          ld.cnt = 4'h0;
          ld.nbyte = (lq.nbyte == 2'h3) ? lq.nbyte : lq.nbyte + 2'h1;
          if (lq.nbyte == 2'h0) begin
            ld.ptr = lq.sh[1:0];
          end else if (lq.nbyte == 2'h1) begin
            if (lq.ptr == `PTR_CFG) begin
              ld.cfg = {lq.sh[7:4], 2'h0, lq.sh[1:0]};
              ld.tog[`EV_CLR] = lq.tog[`EV_CLR] ^ lq.sh[`CFG_ALERT_CLR];
              ld.tog[`EV_SHOT] = lq.tog[`EV_SHOT] ^ lq.sh[`CFG_ONE_SHOT];
            end else if (lq.ptr == `PTR_HIGH && HAS_LIMITS) begin
              ld.thigh = lq.sh;
            end else if (lq.ptr == `PTR_LOW && HAS_LIMITS) begin
              ld.tlow = lq.sh;
            end
            ld.tog[`EV_WORD] = ~lq.tog[`EV_WORD];
          end
        end
      end
      S_WACK: begin
        if (scl_fall) begin
          ld.st = S_WR;
          ld.sda_oe = 1'b0;
        end
      end
      S_RD: begin
        if (scl_rise) begin
          ld.cnt = lq.cnt + 4'h1;
          ld.sh = {lq.sh[6:0], 1'b0};
          if (lq.sh[7] && !lq.sda_s[1]) begin
            ld.st = S_IDLE;
          end
        end else if (scl_fall) begin
          if (lq.cnt == `BYTE_BITS) begin
            ld.st = S_RACK;
            ld.sda_oe = 1'b0;
            ld.cnt = 4'h0;
          end else begin
            ld.sda_oe = ~lq.sh[7];
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          ld.mack = ~lq.sda_s[1];
        end else if (scl_fall) begin
          if (lq.mack) begin
            ld.st = S_RD;
            ld.sh = rbyte;
            ld.sda_oe = ~rbyte[7];
            ld.nbyte = lq.nbyte + 2'h1;
            ld.tog[`EV_RDCLR] = lq.tog[`EV_RDCLR] ^ tbyte2;
          end else begin
            ld.st = S_IDLE;
          end
        end
      end
      default: ;
    endcase
    // Start and stop override any byte in progress.
    if (bus_start) begin
      ld.st = S_ADDR;
      ld.cnt = 4'h0;
      ld.sda_oe = 1'b0;
    end else if (bus_stop) begin
      ld.st = S_IDLE;
      ld.sda_oe = 1'b0;
    end
  end

  // Link-domain register; reset brings up the documented defaults.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
      lq.scl_s <= 2'h3;
      lq.sda_s <= 2'h3;
      lq.scl_p <= 1'b1;
      lq.sda_p <= 1'b1;
      lq.st <= S_IDLE;
      lq.ptr <= `RST_PTR;
      lq.cfg <= `RST_CFG;
      lq.thigh <= `RST_HIGH;
      lq.tlow <= `RST_LOW;
    end else begin
      lq <= ld;
    end
  end

  // ==========================================================================
  // System-clock domain: result, limit compare, flags and alert pin
  logic hi_new;
  logic lo_new;
  logic hi_cur;
  logic lo_cur;
  logic [3:0] ev;

  // Signed compare of limits against the upper eight result bits.
  assign hi_new = HAS_LIMITS && ($signed(temp_in[9:2]) > $signed(cq.thigh));
  assign lo_new = HAS_LIMITS && ($signed(temp_in[9:2]) < $signed(cq.tlow));
  assign hi_cur = HAS_LIMITS && ($signed(cq.temp[9:2]) > $signed(cq.thigh));
  assign lo_cur = HAS_LIMITS && ($signed(cq.temp[9:2]) < $signed(cq.tlow));
  assign ev = cq.tog_s2 ^ cq.tog_seen;

  // Next state of the core domain.
  always_comb begin
    cd = cq;
    cd.tog_s1 = lq.tog;
    cd.tog_s2 = cq.tog_s1;
    cd.tog_seen = cq.tog_s2;
    // Register words change only at a byte boundary, so they are settled here.
    if (ev[`EV_WORD]) begin
      cd.cfg = lq.cfg;
      cd.thigh = lq.thigh;
      cd.tlow = lq.tlow;
    end
    // Clearing re-evaluates against the held result, so a true condition stays.
    if (ev[`EV_RDCLR]) begin
      cd.over_hi = hi_cur;
      cd.under_lo = lo_cur;
    end
    if (temp_load) begin
      cd.temp = temp_in;
      cd.over_hi = cd.over_hi | hi_new;
      cd.under_lo = cd.under_lo | lo_new;
    end
    // Setting wins over a clear arriving in the same cycle.
    if (!HAS_LIMITS || cq.cfg[`CFG_ALERT_DIS]) begin
      cd.alert = 1'b0;
    end else if (temp_load && hi_new) begin
      cd.alert = 1'b1;
    end else if (ev[`EV_CLR] || (temp_load && lo_new)) begin
      cd.alert = 1'b0;
    end
    // Pin pulls low while alerting when active low, while idle when active high.
    cd.alert_oe = cd.alert ^ cq.cfg[`CFG_POL];
    cd.pd = cq.cfg[`CFG_PD];
    cd.filt = cq.cfg[`CFG_FILT];
    cd.shot = ev[`EV_SHOT];
    // A new snapshot goes out only after the link has taken the last one.
    cd.ack_s = {cq.ack_s[0], lq.pub_seen};
    if (cq.ack_s[1] == cq.pub_tog &&
        cq.pub != {cq.temp, cq.alert, cq.over_hi, cq.under_lo}) begin
      cd.pub = {cq.temp, cq.alert, cq.over_hi, cq.under_lo};
      cd.pub_tog = ~cq.pub_tog;
    end
  end

  // Core-domain register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cq <= '0;
      cq.cfg <= `RST_CFG;
      cq.thigh <= `RST_HIGH;
      cq.tlow <= `RST_LOW;
      cq.filt <= 1'b1;
    end else begin
      cq <= cd;
    end
  end

  // Outputs straight from the state registers.
  assign sda_out = lq.sda_out;
  assign sda_oe = lq.sda_oe;
  assign alert_out = cq.alert_out;
  assign alert_oe = cq.alert_oe;
  assign full_power_down = cq.pd;
  assign bus_filter_on = cq.filt;
  assign one_shot_start = cq.shot;

  // ==========================================================================
  // Checks
  // The pin level follows the polarity in force when the alert was computed.
  property p_alert_set;
    @(posedge clk) disable iff (!rst_n)
    (temp_load && hi_new && !cq.cfg[`CFG_ALERT_DIS]) |=>
      cq.alert && (cq.alert_oe != $past(cq.cfg[`CFG_POL]));
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert not raised above limit");
  property p_alert_dis;
    @(posedge clk) disable iff (!rst_n) cq.cfg[`CFG_ALERT_DIS] |=> !cq.alert;
  endproperty
  a_alert_dis: assert property (p_alert_dis) else $error("alert active while disabled");
  property p_alert_pol;
    @(posedge clk) disable iff (!rst_n)
    (cq.alert && !cq.cfg[`CFG_POL] && $stable(cq.cfg)) |-> cq.alert_oe;
  endproperty
  a_alert_pol: assert property (p_alert_pol) else $error("active-low alert not driven");
  property p_alert_low;
    @(posedge clk) disable iff (!rst_n) (temp_load && lo_new && !hi_new) |=> !cq.alert;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert kept below low limit");
  property p_cfg_zero;
    @(posedge link_clk) disable iff (!rst_n) lq.cfg[3:2] == 2'h0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("action bits stored");
  property p_sda_low;
    @(posedge link_clk) disable iff (!rst_n)
    $changed(lq.sda_oe) |-> !$past(lq.scl_s[1]) || $past(bus_stop) || $past(bus_start);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("SDA moved with SCL high");
  property p_ack;
    @(posedge link_clk) disable iff (!rst_n) (lq.st == S_AACK || lq.st == S_WACK) |-> lq.sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");
  property p_ptr_keep;
    @(posedge link_clk) disable iff (!rst_n)
    $changed(lq.ptr) |-> $past(lq.st) == S_WR && $past(lq.nbyte) == 2'h0;
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer changed outside write");

endmodule : temp_sensor_i2c_slave_alert

// file: verif/i2c_host_model.sv
`timescale 1ns/10ps
// ============================================================
// Two-wire bus master model
module i2c_host_model #(
  parameter int QTR = 6
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // SDA idles released and SCL is driven high; the pull-up holds SDA high between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic qwait();
    repeat (QTR) @(posedge clk);
  endtask : qwait

  // SDA falls while SCL is high.
  task automatic start();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask : start

  // SDA rises while SCL is high, after the last acknowledge.
  task automatic stop();
    sda_low <= 1'b1;
    qwait();
    scl <= 1'b1;
    qwait();
    sda_low <= 1'b0;
    qwait();
  endtask : stop

  // SDA moves a quarter period after SCL fell, never while SCL is high.
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    qwait();
    scl <= 1'b1;
    qwait();
    r = sda;
    qwait();
    scl <= 1'b0;
    qwait();
  endtask : bit_x

  // Eight bits MSB first, then the ninth clock releases SDA for the acknowledge.
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, ack);
  endtask : put

  // The last byte of a read is answered with a not-acknowledge.
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~more, r);
  endtask : get
endmodule : i2c_host_model

// file: verif/tb.sv
`timescale 1ns/10ps
// ============================================================
// Testbench
module tb;
  import tsense_pkg::*;
  localparam logic [6:0] dev_addr = 7'h48;
  logic clk, link_clk, rst_n, scl, m_low, temp_load;
  logic [9:0] temp_in;
  strap_t strap;
  logic sda_out, sda_oe, alert_out, alert_oe, full_power_down, bus_filter_on, one_shot_start;
  logic sda_w, alert_pin;
  int n_mismatch, tests_run, n_shot;

  // Open-drain wires with pull-ups: any party pulling wins.
  assign sda_w = !(m_low || (sda_oe && !sda_out));
  assign alert_pin = !(alert_oe && !alert_out);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Link clock runs at 15 ns with an odd phase offset.
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  temp_sensor_i2c_slave_alert u_dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(strap), .temp_in(temp_in),
    .temp_load(temp_load), .alert_out(alert_out), .alert_oe(alert_oe),
    .full_power_down(full_power_down), .bus_filter_on(bus_filter_on),
    .one_shot_start(one_shot_start)
  );

  i2c_host_model u_host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(m_low));

  always @(posedge clk) begin
    if (one_shot_start === 1'b1) begin
      n_shot <= n_shot + 1;
    end
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Bus traffic waits well past the strap capture after release.
  task automatic do_reset(input strap_t s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset

  task automatic ld(input logic [9:0] t);
    @(posedge clk);
    temp_in <= t;
    temp_load <= 1'b1;
    @(posedge clk);
    temp_load <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ld

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input int two);
    logic a;
    u_host.start();
    u_host.put({dev_addr, 1'b0}, a);
    chk(16'(a), 16'h0);
    u_host.put(p, a);
    chk(16'(a), 16'h0);
    if (two != 0) begin
      u_host.put(d, a);
      chk(16'(a), 16'h0);
    end
    u_host.stop();
  endtask : wr

  // Each read is its own operation, opened by a fresh start.
  task automatic rd(input logic [6:0] ad, input int n, output logic [15:0] v, output logic a);
    logic [7:0] b;
    v = 16'h0;
    u_host.start();
    u_host.put({ad, 1'b1}, a);
    if (a === 1'b0) begin
      for (int i = 0; i < n; i++) begin
        u_host.get(i < n - 1, b);
        v = {v[7:0], b};
      end
    end
    u_host.stop();
  endtask : rd

  // ============================================================
  // Scenarios
  task automatic t_strap();
    logic [15:0] v;
    logic a;
    strap_t s[3] = '{AS_GND, AS_VDD, AS_FLOAT};
    logic [2:0] lo[3] = '{3'h0, 3'h1, 3'h2};
    for (int i = 0; i < 3; i++) begin
      do_reset(s[i]);
      rd({4'h9, lo[i]}, 1, v, a);
      chk(16'(a), 16'h0);
      rd({4'h9, lo[i] ^ 3'h4}, 1, v, a);
      chk(16'(a), 16'h1);
    end
    do_reset(AS_GND);
  endtask : t_strap

  task automatic t_defaults();
    logic [15:0] v;
    logic a;
    logic [7:0] exp[3] = '{8'h40, 8'h7f, 8'h80};
    chk(16'(bus_filter_on), 16'h1);
    chk(16'(full_power_down), 16'h0);
    chk(16'(alert_pin), 16'h1);
    ld(10'h2d6);
    rd(dev_addr, 2, v, a);
    chk(v, 16'hb580);
    for (int p = 1; p < 4; p++) begin
      wr(8'(p), 8'h0, 0);
      rd(dev_addr, 1, v, a);
      chk(v, 16'(exp[p - 1]));
      rd(dev_addr, 1, v, a);
      chk(v, 16'(exp[p - 1]));
    end
  endtask : t_defaults

  task automatic t_write();
    logic [15:0] v;
    logic a;
    int s0;
    s0 = n_shot;
    wr(8'h01, 8'hcc, 1);
    rd(dev_addr, 1, v, a);
    chk(v, 16'h00c0);
    chk(16'(full_power_down), 16'h1);
    chk(16'(bus_filter_on), 16'h1);
    chk(16'(n_shot - s0), 16'h1);
    wr(8'h01, 8'h00, 1);
    chk(16'(bus_filter_on), 16'h0);
    wr(8'h01, 8'h40, 1);
    wr(8'h02, 8'h00, 0);
    rd(dev_addr, 1, v, a);
    chk(v, 16'h007f);
    wr(8'h03, 8'h05, 1);
    rd(dev_addr, 1, v, a);
    chk(v, 16'h0005);
    wr(8'h02, 8'h10, 1);
    rd(dev_addr, 1, v, a);
    chk(v, 16'h0010);
  endtask : t_write

  // Limits are now high 10 and low 05, alert active low and enabled.
  task automatic t_alert();
    logic [15:0] v;
    logic a;
    ld(10'h047);
    chk(16'(alert_pin), 16'h0);
    wr(8'h00, 8'h00, 0);
    rd(dev_addr, 2, v, a);
    chk(v, 16'h11f0);
    rd(7'h0c, 1, v, a);
    chk(16'(a), 16'h0);
    chk(v, 16'h0090);
    wr(8'h01, 8'h50, 1);
    chk(16'(alert_pin), 16'h1);
    wr(8'h01, 8'h70, 1);
    chk(16'(alert_pin), 16'h0);
    wr(8'h01, 8'h48, 1);
    chk(16'(alert_pin), 16'h1);
    rd(7'h0c, 1, v, a);
    chk(16'(a), 16'h1);
    ld(10'h047);
    chk(16'(alert_pin), 16'h0);
    wr(8'h01, 8'h48, 1);
    chk(16'(alert_pin), 16'h1);
    ld(10'h047);
    chk(16'(alert_pin), 16'h0);
    ld(10'h3fc);
    chk(16'(alert_pin), 16'h1);
    wr(8'h00, 8'h00, 0);
    rd(dev_addr, 2, v, a);
    chk(v, 16'hff18);
    rd(dev_addr, 2, v, a);
    chk(v, 16'hff08);
  endtask : t_alert

  // ============================================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    temp_load = 1'b0;
    temp_in = 10'h0;
    strap = AS_GND;
    n_mismatch = 0;
    tests_run = 0;
    t_strap();
    t_defaults();
    t_write();
    t_alert();
    test_done();
  end

  // The run needs about 19000 cycles; over four times that means a hang.
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : tb
